// ### src/slofu_top.sv
/*
  Synchronous local-oscillator frequency update control for one digitizer module.
  Assumes the timing line and all control inputs are synchronous to the shared ADC clock,
  and that the controller keeps peer modules in a common state before each transition.
  A pending word is applied only on a line transition, so every peer that sees the same
  edge on the same clock cycle changes its oscillator together and phases stay aligned.
  No register interface: the host side arrives as plain strobes and a data word.
  The decimation counter here only marks the restart point; the filter datapath that
  consumes it lives elsewhere in the module.
*/
`timescale 1ns/1ps
module slofu_top #(
  parameter int FREQ_W = slofu_pkg::FREQ_W,
  parameter int DEC_W  = slofu_pkg::DEC_W
) (
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              sync_line_i,
  input  wire logic              freq_load_i,
  input  wire logic [FREQ_W-1:0] freq_value_i,
  input  wire logic              filter_prep_i,
  input  wire logic              continuous_mode_i,
  input  wire logic              meas_start_i,
  input  wire logic              meas_stop_i,
  output logic [FREQ_W-1:0]      local_oscillator_freq_o,
  output logic                   freq_pending_o,
  output logic                   freq_applied_o,
  output logic                   phase_reset_o,
  output logic                   arm_o,
  output logic [1:0]             state_o,
  output logic [DEC_W-1:0]       dec_count_o,
  output logic                   dec_running_o,
  output logic                   phase_sync_lost_o
);
  // Line transition seen this cycle
  logic                    sync_edge;
  // Measurement sequencing
  slofu_pkg::slofu_state_t state_reg;
  slofu_pkg::slofu_state_t state_next;
  // Pending and active oscillator words
  logic [FREQ_W-1:0]       pend_reg;
  logic [FREQ_W-1:0]       freq_reg;
  logic                    pend_valid_reg;
  // Filter restart waiting for the next transition
  logic                    filt_pend_reg;
  // Decimation restart marker
  logic [DEC_W-1:0]        dec_reg;
  logic                    dec_run_reg;
  // One-cycle reports and the phase-lost level
  logic                    applied_reg;
  logic                    phrst_reg;
  logic                    arm_reg;
  logic                    lost_reg;

  // States that accept a frequency update at the shared edge
  function automatic logic slofu_upd_ok(input slofu_pkg::slofu_state_t st,
                                        input logic                    cont);
    logic ok;
    ok = (st == slofu_pkg::SLOFU_IDLE);
    if ((st == slofu_pkg::SLOFU_MEASURE) && cont) begin
      ok = 1'b1;
    end
    return ok;
  endfunction : slofu_upd_ok

  slofu_edge u_edge (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .line_i    (sync_line_i),
    .edge_o    (sync_edge)
  );

  // Decode of what the transition does this cycle
  wire is_idle     = (state_reg == slofu_pkg::SLOFU_IDLE);
  // Armed is never a legal update point, so block mode only updates from Idle
  wire upd_allowed = slofu_upd_ok(state_reg, continuous_mode_i);
  wire do_update   = sync_edge & pend_valid_reg & upd_allowed;
  wire do_rearm    = sync_edge & is_idle & (pend_valid_reg | filt_pend_reg);
  wire do_filt     = sync_edge & filt_pend_reg & is_idle;

  // Measurement sequencing; a filter preparation ends any measurement
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      slofu_pkg::SLOFU_IDLE: begin
        if (do_rearm) begin
          state_next = slofu_pkg::SLOFU_ARMED;
        end else if (meas_start_i) begin
          state_next = slofu_pkg::SLOFU_ARMED;
        end
      end
      slofu_pkg::SLOFU_ARMED: begin
        if (filter_prep_i | meas_stop_i) begin
          state_next = slofu_pkg::SLOFU_IDLE;
        end else begin
          state_next = slofu_pkg::SLOFU_MEASURE;
        end
      end
      slofu_pkg::SLOFU_MEASURE: begin
        // Continuous measurement carries on across an update
        if (filter_prep_i | meas_stop_i) begin
          state_next = slofu_pkg::SLOFU_IDLE;
        end
      end
      default: begin
        state_next = slofu_pkg::SLOFU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= slofu_pkg::SLOFU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pending frequency: a new load wins over consumption in the same cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pend_reg       <= FREQ_W'(slofu_pkg::FREQ_RST);
      pend_valid_reg <= 1'b0;
    end else if (freq_load_i) begin
      pend_reg       <= freq_value_i;
      pend_valid_reg <= 1'b1;
    end else if (do_update) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // Active oscillator frequency, changed only on the shared edge
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      freq_reg    <= FREQ_W'(slofu_pkg::FREQ_RST);
      applied_reg <= 1'b0;
      phrst_reg   <= 1'b0;
      arm_reg     <= 1'b0;
    end else begin
      if (do_update) begin
        freq_reg <= pend_reg;
      end
      applied_reg <= do_update;
      phrst_reg   <= do_update; // Common phase restart across modules
      arm_reg     <= do_rearm;
    end
  end

  // Filter preparation held until the next edge while Idle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      filt_pend_reg <= 1'b0;
    end else if (filter_prep_i) begin
      filt_pend_reg <= 1'b1; // Set wins over the clear
    end else if (do_filt) begin
      filt_pend_reg <= 1'b0;
    end
  end

  // Decimation counter restarts on the edge after preparation;
  // a new preparation in the restart cycle wins and keeps the counter stopped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dec_reg     <= '0;
      dec_run_reg <= 1'b0;
    end else if (filter_prep_i) begin
      dec_run_reg <= 1'b0;
    end else if (do_filt) begin
      dec_reg     <= '0;
      dec_run_reg <= 1'b1;
    end else if (dec_run_reg) begin
      dec_reg <= dec_reg + DEC_W'(1);
    end
  end

  // Filter change breaks oscillator phase until the next frequency update
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lost_reg <= 1'b0;
    end else if (do_filt) begin
      lost_reg <= 1'b1;
    end else if (do_update) begin
      lost_reg <= 1'b0;
    end
  end

  // Every output comes straight from a register, so peers see clean levels
  assign local_oscillator_freq_o = freq_reg;
  assign freq_pending_o          = pend_valid_reg;
  assign freq_applied_o          = applied_reg;
  assign phase_reset_o           = phrst_reg;
  assign arm_o                   = arm_reg;
  assign state_o                 = state_reg;
  assign dec_count_o             = dec_reg;
  assign dec_running_o           = dec_run_reg;
  assign phase_sync_lost_o       = lost_reg;
endmodule : slofu_top

// ### src/slofu_pkg.sv
/*
  Constants and types for the synchronous local-oscillator frequency update block.
  Assumes one shared ADC clock drives every module and the shared timing line.
*/
// Summary of operation
// - The host loads a pending frequency beforehand and the module holds it until a line transition that finds it in a state that accepts an update.
// - Every module applies the pending frequency on the same line transition so oscillator phases stay aligned.
// - An Idle module at the transition updates its oscillator frequency and arms the next measurement in the same cycle.
// - A module measuring in continuous mode updates its frequency at the transition and keeps measuring.
// - In block mode a transition is ignored for frequency update unless the module is Idle.
// - A filter change loses oscillator phase sync, so filters are synchronised before frequency.
// - Line transitions avoid the ADC clock setup and hold window so all modules see the same cycle.
// - After a filter preparation the module is Idle and the next transition resets and restarts decimation.
package slofu_pkg;
  localparam int FREQ_W        = 32;
  localparam int DEC_W         = 16;
  localparam logic [31:0] FREQ_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    SLOFU_IDLE    = 2'b00,
    SLOFU_ARMED   = 2'b01,
    SLOFU_MEASURE = 2'b10
  } slofu_state_t;
endpackage : slofu_pkg

// ### src/slofu_edge.sv
/*
  Edge detector for the shared timing line.
  Assumes the line is already synchronous to clk_i (transitions avoid setup/hold).
*/
`timescale 1ns/1ps
module slofu_edge (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic line_i,
  output logic      edge_o
);
  logic line_reg;

  // Previous sample of the line; no synchroniser since all modules must agree
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      line_reg <= 1'b0;
    end else begin
      line_reg <= line_i;
    end
  end

  // Either direction counts as a transition
  assign edge_o = line_reg ^ line_i;
endmodule : slofu_edge

// ### sim/slofu_properties.sv
/* Checker on the slofu_top ports.
   Assumes binding into slofu_top and one clock domain. */
`timescale 1ns/1ps
module slofu_properties #(
  parameter int FREQ_W = 32,
  parameter int DEC_W  = 16
) (
  input wire logic              clk_i,
  input wire logic              sys_rst_i,
  input wire logic              sync_line_i,
  input wire logic              freq_load_i,
  input wire logic              filter_prep_i,
  input wire logic              continuous_mode_i,
  input wire logic              meas_stop_i,
  input wire logic [FREQ_W-1:0] local_oscillator_freq_o,
  input wire logic              freq_pending_o,
  input wire logic              freq_applied_o,
  input wire logic              phase_reset_o,
  input wire logic              arm_o,
  input wire logic [1:0]        state_o,
  input wire logic [DEC_W-1:0]  dec_count_o,
  input wire logic              dec_running_o
);
  logic line_reg;
  // Own copy of the line sample, reset to 0 like the design's
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) line_reg <= 1'b0;
    else line_reg <= sync_line_i;
  end
  wire edge_w = sync_line_i ^ line_reg;
  wire calm_w = !filter_prep_i && !meas_stop_i; // Prep or stop override the state step, not the update
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_IDLE_ARM: assert property (edge_w && state_o == 2'h0 && freq_pending_o && calm_w
    |=> freq_applied_o && arm_o && state_o == 2'h1) else $error("idle update did not arm");
  AST_CONT_RUN: assert property (edge_w && state_o == 2'h2 && continuous_mode_i
    && freq_pending_o && calm_w |=> freq_applied_o && !arm_o && state_o == 2'h2)
    else $error("continuous update");
  AST_BLOCK_IGN: assert property (edge_w && !continuous_mode_i && state_o != 2'h0
    |=> !freq_applied_o && $stable(local_oscillator_freq_o)) else $error("block busy update");
  AST_APPLY_EDGE: assert property (freq_applied_o |-> $past(edge_w))
    else $error("update without line edge");
  AST_APPLY_ONCE: assert property (freq_applied_o
    |-> !freq_pending_o || $past(freq_load_i)) else $error("pending kept after update");
  AST_PEND_HOLD: assert property (freq_pending_o && !edge_w |=> freq_pending_o)
    else $error("pending lost without edge");
  AST_LOAD: assert property (freq_load_i |=> freq_pending_o)
    else $error("load not held");
  AST_PHASE: assert property (phase_reset_o == freq_applied_o)
    else $error("phase reset");
  AST_DEC_RESTART: assert property ($rose(dec_running_o)
    |-> dec_count_o == '0 && $past(edge_w)) else $error("decimation restart");
  AST_ARMED_ONE: assert property (state_o == 2'h1 && calm_w |=> state_o == 2'h2)
    else $error("armed not followed by measure");
  cover property (freq_applied_o && arm_o);
  cover property (freq_applied_o && !arm_o);
  cover property ($rose(dec_running_o));
endmodule : slofu_properties
bind slofu_top slofu_properties #(.FREQ_W(FREQ_W), .DEC_W(DEC_W)) u_props (.*);

// ### sim/slofu_peer.sv
/* Peer side model: drives the shared timing line.
   Assumes toggle requests come from the bench, one per cycle at most. */
`timescale 1ns/1ps
module slofu_peer (
  input  wire logic clk_i,
  input  wire logic toggle_i,
  output logic      sync_line_o = 1'b0
);
  // Change 1 ns after the edge, clear of setup and hold; one line for all peers
  always @(posedge clk_i) begin
    if (toggle_i) sync_line_o <= #1 ~sync_line_o;
  end
endmodule : slofu_peer

// ### sim/slofu_top_bench.sv
/* Self-checking bench for slofu_top with the peer line model.
   Assumes the 200 MHz shared clock and no random stimulus. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end end
module slofu_top_bench;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, tog = 1'b0, load_r = 1'b0, prep = 1'b0, cont = 1'b0;
  logic        start = 1'b0, stop = 1'b0;
  logic [31:0] value = 32'h0;
  wire  [31:0] lo_freq;
  wire  [15:0] dcnt;
  wire         line, pend, appl, arm, running, lost, phrst;
  wire  [1:0]  st;
  int          n_fail = 0, checked = 0;
  bit          got;
  slofu_peer peer (.clk_i(clk_i), .toggle_i(tog), .sync_line_o(line));
  slofu_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sync_line_i(line), .freq_load_i(load_r),
    .freq_value_i(value), .filter_prep_i(prep), .continuous_mode_i(cont), .meas_start_i(start),
    .meas_stop_i(stop), .local_oscillator_freq_o(lo_freq), .freq_pending_o(pend),
    .freq_applied_o(appl), .phase_reset_o(phrst), .arm_o(arm), .state_o(st), .dec_count_o(dcnt),
    .dec_running_o(running), .phase_sync_lost_o(lost));
  initial begin forever #2.5 clk_i = ~clk_i; end
  task automatic final_report();
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Inputs move 1 ns after the edge so no sampling race
  task automatic step(); @(posedge clk_i); #1; endtask : step
  task automatic load(input logic [31:0] v);
    load_r = 1'b1; value = v; step(); load_r = 1'b0; step();
  endtask : load
  // Bounded wait for a condition after one line toggle
  task automatic sync_wait(input int n, input bit dec);
    tog = 1'b1; step(); tog = 1'b0; got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin step(); got = dec ? running : appl; end
  endtask : sync_wait
  task automatic s_idle();
    load(32'h1234_5678); `CHK(pend, 1'b1)
    sync_wait(8, 0); `CHK(got, 1'b1)
    if (!got) final_report();
    `CHK(lo_freq, 32'h1234_5678)
    `CHK(phrst, 1'b1)
    `CHK(arm, 1'b1)
    `CHK(pend, 1'b0)
    step(); `CHK(st, 2'h2)
  endtask : s_idle
  task automatic s_block();
    load(32'h0bad_f00d); sync_wait(4, 0); `CHK(got, 1'b0)
    `CHK(lo_freq, 32'h1234_5678)
    `CHK(pend, 1'b1)
  endtask : s_block
  task automatic s_cont();
    cont = 1'b1; sync_wait(8, 0); `CHK(got, 1'b1)
    `CHK(lo_freq, 32'h0bad_f00d)
    `CHK(arm, 1'b0)
    step(); `CHK(st, 2'h2)
  endtask : s_cont
  task automatic s_filter();
    prep = 1'b1; step(); prep = 1'b0; step(); `CHK(st, 2'h0)
    sync_wait(8, 1); `CHK(got, 1'b1)
    `CHK(dcnt, 16'h0)
    `CHK(lost, 1'b1)
    load(32'h0000_0100); sync_wait(8, 0); `CHK(got, 1'b1)
    `CHK(lost, 1'b0)
  endtask : s_filter
  // Idle module in continuous mode re-arms instead of continuing
  task automatic s_stop();
    stop = 1'b1; step(); stop = 1'b0; `CHK(st, 2'h0)
    load(32'h0000_0200); sync_wait(8, 0); `CHK(got, 1'b1)
    `CHK(arm, 1'b1)
    `CHK(lo_freq, 32'h0000_0200)
    step(); stop = 1'b1; step(); stop = 1'b0; start = 1'b1; step(); start = 1'b0;
    `CHK(st, 2'h1)
  endtask : s_stop
  // Mid-run reset returns state, frequency and pending to their reset values
  task automatic s_reset();
    sys_rst_i = 1'b1; step(); `CHK(st, 2'h0)
    `CHK(lo_freq, slofu_pkg::FREQ_RST)
    `CHK(pend, 1'b0)
    sys_rst_i = 1'b0; step(); `CHK(appl, 1'b0)
  endtask : s_reset
  initial begin
    repeat (5) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    s_idle();
    s_block();
    s_cont();
    s_filter();
    s_stop();
    s_reset();
    final_report();
  end
endmodule : slofu_top_bench
